// [boot_store_flash_sequencer.v]
// Function
// - ID read sends identify opcode, then clocks in exactly three bytes.
// - Status read sends status opcode, then receives one status byte.
// - Status bit 0 means busy, bit 1 means write enable latched.
// - Write enable sends its opcode, then polls until write-enable bit set.
// - Chip erase sends its opcode, then polls until busy clears.
// - Data read sends opcode and 24-bit address, then any byte count.
// - Page program sends opcode, 24-bit address, then 1 to 255 bytes.
// - Sector erase sends opcode and 24-bit address, then polls busy.
// - Every erasable sector is treated as four kilobytes.
// - File-system region starts fixed at flash address zero.
// - Files take whole four-kilobyte blocks, at least one block.
// - At most 128 files in total.
// - Fail-safe files take double size, at least eight kilobytes.
// - Files larger than sixteen megabytes are rejected.
// - Discoverable parameter table can be read from the flash.
`timescale 1ns/1ps
`default_nettype none
`include "serial_flash_defines.vh"

module boot_store_flash_sequencer (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Command port
  input wire cmd_valid,
  output reg cmd_ready,
  input wire [2:0] cmd_op,
  input wire [23:0] cmd_addr,
  input wire [15:0] cmd_len,
  output reg cmd_done,
  output reg cmd_error,
  // Program data stream
  input wire wr_valid,
  output wire wr_ready,
  input wire [7:0] wr_data,
  // Read data stream
  output reg rd_valid,
  output reg [7:0] rd_data,
  output reg [7:0] status_byte,
  // File allocation check
  input wire alloc_valid,
  input wire [24:0] alloc_size,
  input wire alloc_failsafe,
  input wire alloc_release,
  output reg alloc_done,
  output reg alloc_ok,
  output reg [13:0] alloc_blocks,
  output reg [7:0] file_count,
  // Flash pins
  output reg flash_cs_n,
  output reg flash_sclk,
  output reg flash_mosi,
  input wire flash_miso
);

  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_OP = 4'h1;
  localparam [3:0] S_ADDR = 4'h2;
  localparam [3:0] S_DUMMY = 4'h3;
  localparam [3:0] S_READ = 4'h4;
  localparam [3:0] S_WRITE = 4'h5;
  localparam [3:0] S_END = 4'h6;
  localparam [3:0] S_POLL_OP = 4'h7;
  localparam [3:0] S_POLL_RD = 4'h8;

  localparam [7:0] DIV_LAST = `LINK_HALF_CYC - 1;
  localparam [7:0] GAP_LAST = `CS_GAP_CYC - 1;

  // Input synchroniser
  reg miso_meta;
  reg miso_s;

  // Byte engine
  reg eng_busy;
  reg [7:0] eng_tx;
  reg [7:0] eng_rx;
  reg [2:0] bit_cnt;
  reg [7:0] div_cnt;
  reg byte_done;

  // Sequencer
  reg [3:0] state;
  reg [2:0] op;
  reg [23:0] addr_sh;
  reg [1:0] addr_idx;
  reg [15:0] count;
  reg armed;
  reg poll;
  reg [7:0] gap_cnt;

  // Combinational helpers
  reg [7:0] opcode;
  reg [7:0] tx_sel;
  reg shifting;
  wire launch;
  wire fifo_valid;
  wire [7:0] fifo_data;
  wire fifo_pop;
  wire poll_met;

  // Program data buffer
  prog_data_fifo #(
    .WIDTH(8),
    .DEPTH(8),
    .AW(3)
  ) u_prog_fifo (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // Two-stage sync of the data pin
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      miso_meta <= 1'b0;
      miso_s <= 1'b0;
    end else begin
      miso_meta <= flash_miso;
      miso_s <= miso_meta;
    end
  end

  // Opcode per command
  always @* begin
    case (op)
      `CMD_READ_ID: opcode = `OPC_READ_ID;
      `CMD_READ_STATUS: opcode = `OPC_READ_STATUS;
      `CMD_WRITE_ENABLE: opcode = `OPC_WRITE_ENABLE;
      `CMD_CHIP_ERASE: opcode = `OPC_CHIP_ERASE;
      `CMD_SECTOR_ERASE: opcode = `OPC_SECTOR_ERASE;
      `CMD_READ_DATA: opcode = `OPC_READ_DATA;
      `CMD_PAGE_PROGRAM: opcode = `OPC_PAGE_PROGRAM;
      default: opcode = `OPC_READ_PARAMS;
    endcase
  end

  // Byte to shift out in each state
  always @* begin
    shifting = 1'b1;
    case (state)
      S_OP: tx_sel = opcode;
      S_ADDR: tx_sel = addr_sh[23:16];
      S_DUMMY: tx_sel = 8'h00;
      S_WRITE: tx_sel = fifo_data;
      S_POLL_OP: tx_sel = `OPC_READ_STATUS;
      S_READ: tx_sel = 8'h00;
      S_POLL_RD: tx_sel = 8'h00;
      default: begin
        tx_sel = 8'h00;
        shifting = 1'b0;
      end
    endcase
  end

  // Start a byte once engine idle; program stalls on empty buffer
  assign launch = shifting && !eng_busy && !armed && (state != S_WRITE || fifo_valid);
  assign fifo_pop = launch && (state == S_WRITE);

  // Poll exit: write enable waits for latch, others wait for not busy
  assign poll_met = (op == `CMD_WRITE_ENABLE) ? eng_rx[`STATUS_WEL_BIT] :
                    !eng_rx[`STATUS_BUSY_BIT];

  // Mode 0 byte shifter, half period from divider
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      eng_busy <= 1'b0;
      eng_tx <= 8'h00;
      eng_rx <= 8'h00;
      bit_cnt <= 3'h0;
      div_cnt <= 8'h00;
      byte_done <= 1'b0;
      flash_sclk <= 1'b0;
      flash_mosi <= 1'b0;
    end else begin
      byte_done <= 1'b0;
      if (launch) begin
        eng_busy <= 1'b1;
        eng_tx <= tx_sel;
        flash_mosi <= tx_sel[7];
        bit_cnt <= 3'h0;
        div_cnt <= 8'h00;
      end else if (eng_busy) begin
        if (div_cnt == DIV_LAST) begin
          div_cnt <= 8'h00;
          if (!flash_sclk) begin
            flash_sclk <= 1'b1;
            eng_rx <= {eng_rx[6:0], miso_s};
          end else begin
            flash_sclk <= 1'b0;
            if (bit_cnt == 3'h7) begin
              eng_busy <= 1'b0;
              byte_done <= 1'b1;
            end else begin
              bit_cnt <= bit_cnt + 3'h1;
              flash_mosi <= eng_tx[6];
              eng_tx <= {eng_tx[6:0], 1'b0};
            end
          end
        end else begin
          div_cnt <= div_cnt + 8'h01;
        end
      end
    end
  end

  // Command sequencer
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      op <= `CMD_READ_ID;
      addr_sh <= `FS_BASE_ADDR;
      addr_idx <= 2'h0;
      count <= 16'h0000;
      armed <= 1'b0;
      poll <= 1'b0;
      gap_cnt <= 8'h00;
      cmd_ready <= 1'b1;
      cmd_done <= 1'b0;
      cmd_error <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      status_byte <= 8'h00;
      flash_cs_n <= 1'b1;
    end else begin
      cmd_done <= 1'b0;
      cmd_error <= 1'b0;
      rd_valid <= 1'b0;
      if (launch) begin
        armed <= 1'b1;
      end
      case (state)
        S_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            if (cmd_op == `CMD_PAGE_PROGRAM &&
                (cmd_len == 16'h0000 || cmd_len > `PROG_MAX_BYTES)) begin
              cmd_error <= 1'b1;
              cmd_done <= 1'b1;
            end else begin
              cmd_ready <= 1'b0;
              op <= cmd_op;
              count <= cmd_len;
              addr_idx <= 2'h0;
              poll <= 1'b0;
              flash_cs_n <= 1'b0;
              state <= S_OP;
              if (cmd_op == `CMD_SECTOR_ERASE) begin
                addr_sh <= cmd_addr & `SECTOR_MASK;
              end else begin
                addr_sh <= cmd_addr;
              end
            end
          end
        end
        S_OP: begin
          if (byte_done) begin
            armed <= 1'b0;
            case (op)
              `CMD_READ_ID: begin
                count <= `ID_BYTES;
                state <= S_READ;
              end
              `CMD_READ_STATUS: begin
                count <= `STATUS_BYTES;
                state <= S_READ;
              end
              `CMD_WRITE_ENABLE, `CMD_CHIP_ERASE: begin
                poll <= 1'b1;
                state <= S_END;
              end
              default: state <= S_ADDR;
            endcase
          end
        end
        S_ADDR: begin
          if (byte_done) begin
            armed <= 1'b0;
            addr_sh <= {addr_sh[15:0], 8'h00};
            addr_idx <= addr_idx + 2'h1;
            if (addr_idx == 2'h2) begin
              case (op)
                `CMD_SECTOR_ERASE: begin
                  poll <= 1'b1;
                  state <= S_END;
                end
                `CMD_PAGE_PROGRAM: state <= S_WRITE;
                `CMD_READ_PARAMS: state <= S_DUMMY;
                default: state <= (count == 16'h0000) ? S_END : S_READ;
              endcase
            end
          end
        end
        S_DUMMY: begin
          if (byte_done) begin
            armed <= 1'b0;
            state <= (count == 16'h0000) ? S_END : S_READ;
          end
        end
        S_READ: begin
          if (byte_done) begin
            armed <= 1'b0;
            rd_valid <= 1'b1;
            rd_data <= eng_rx;
            if (op == `CMD_READ_STATUS) begin
              status_byte <= eng_rx;
            end
            count <= count - 16'h0001;
            if (count == 16'h0001) begin
              state <= S_END;
            end
          end
        end
        S_WRITE: begin
          if (byte_done) begin
            armed <= 1'b0;
            count <= count - 16'h0001;
            if (count == 16'h0001) begin
              poll <= 1'b1;
              state <= S_END;
            end
          end
        end
        S_END: begin
          flash_cs_n <= 1'b1;
          if (gap_cnt == GAP_LAST) begin
            gap_cnt <= 8'h00;
            if (poll) begin
              flash_cs_n <= 1'b0;
              state <= S_POLL_OP;
            end else begin
              cmd_done <= 1'b1;
              cmd_ready <= 1'b1;
              state <= S_IDLE;
            end
          end else begin
            gap_cnt <= gap_cnt + 8'h01;
          end
        end
        S_POLL_OP: begin
          if (byte_done) begin
            armed <= 1'b0;
            state <= S_POLL_RD;
          end
        end
        S_POLL_RD: begin
          if (byte_done) begin
            armed <= 1'b0;
            status_byte <= eng_rx;
            if (poll_met) begin
              poll <= 1'b0;
            end
            state <= S_END;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // File allocation sizing
  reg [13:0] next_blocks;
  reg [13:0] base_blocks;
  always @* begin
    base_blocks = {1'b0, alloc_size[24:`BLOCK_SHIFT]} + {13'h0000, |alloc_size[11:0]};
    if (base_blocks == 14'h0000) begin
      base_blocks = 14'h0001;
    end
    next_blocks = base_blocks;
    if (alloc_failsafe) begin
      next_blocks = {base_blocks[12:0], 1'b0};
      if (next_blocks < `FAILSAFE_MIN_BLOCKS) begin
        next_blocks = `FAILSAFE_MIN_BLOCKS;
      end
    end
  end

  // Allocation verdict and file count
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      alloc_done <= 1'b0;
      alloc_ok <= 1'b0;
      alloc_blocks <= 14'h0000;
      file_count <= 8'h00;
    end else begin
      alloc_done <= alloc_valid;
      if (alloc_valid) begin
        alloc_blocks <= next_blocks;
        if (alloc_size > `MAX_FILE_SIZE || file_count >= `MAX_FILES) begin
          alloc_ok <= 1'b0;
          if (alloc_release && file_count != 8'h00) begin
            file_count <= file_count - 8'h01;
          end
        end else begin
          alloc_ok <= 1'b1;
          if (!alloc_release) begin
            file_count <= file_count + 8'h01;
          end
        end
      end else if (alloc_release && file_count != 8'h00) begin
        file_count <= file_count - 8'h01;
      end
    end
  end

endmodule // boot_store_flash_sequencer

`default_nettype wire

// [flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_model #(
  parameter int BUSY_POLLS = 2,
  parameter logic [23:0] ID_CODE = 24'h5e_17a4 // Arbitrary identity value
) (
  // Link pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  output var logic miso
);
  // Frame state and traffic record
  logic [7:0] op = 8'h00;
  logic [7:0] sh = 8'h00;
  logic [7:0] ob;
  logic [23:0] addr = 24'h00_0000;
  logic [23:0] last_addr = 24'h00_0000;
  logic wel = 1'b0;
  logic wel_pend = 1'b0;
  int busy = 0;
  int polls = 0;
  int frames = 0;
  int nbit = 0;
  logic [7:0] prog[$];
  initial miso = 1'b0;
  // Byte answered at each frame position
  function automatic logic [7:0] resp(input int i);
    if (op == 8'h9f && i >= 1 && i <= 3) return ID_CODE[(3 - i) * 8 +: 8];
    if (op == 8'h05 && i == 1) return {6'h00, wel, busy != 0};
    if (op == 8'h03 && i >= 4) return (addr[7:0] + 8'(i - 4)) ^ 8'ha5;
    if (op == 8'h5a && i >= 5) return (addr[7:0] + 8'(i - 5)) ^ 8'h3c;
    return 8'h00;
  endfunction
  // Sample on the rising link edge
  always @(posedge sclk) if (!cs_n) begin
    sh = {sh[6:0], mosi};
    nbit = nbit + 1;
    if (nbit == 8) op = sh;
    else if (nbit % 8 == 0 && nbit <= 32) addr = {addr[15:0], sh};
    else if (nbit % 8 == 0 && op == 8'h02) prog.push_back(sh);
    if (nbit == 8 && sh == 8'h02) prog.delete();
  end
  // Answer bits leave on the falling edge
  always @(negedge sclk) if (!cs_n) begin
    ob = resp(nbit / 8);
    miso <= ob[7 - nbit % 8];
  end
  // New frame restarts the bit count
  always @(negedge cs_n) nbit = 0;
  // Frame end: data line inverted, busy and latch timers run
  always @(posedge cs_n) begin
    miso <= ~miso;
    frames = frames + 1;
    if (op == 8'h05) begin
      polls = polls + 1;
      if (busy > 0) busy = busy - 1;
      if (wel_pend) wel = 1'b1;
      wel_pend = 1'b0;
    end
    if (op == 8'h06) wel_pend = 1'b1;
    if (op == 8'h02 || op == 8'h20 || op == 8'hc7) begin
      busy = BUSY_POLLS;
      wel = 1'b0;
    end
    if (op == 8'h02 || op == 8'h20 || op == 8'h03 || op == 8'h5a) last_addr = addr;
    op = 8'h00;
  end
endmodule // flash_model
`default_nettype wire

// [flash_seq_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_seq_sva (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Command port
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [2:0] cmd_op,
  input wire logic [15:0] cmd_len,
  input wire logic cmd_done,
  input wire logic cmd_error,
  // Allocation
  input wire logic alloc_valid,
  input wire logic [24:0] alloc_size,
  input wire logic alloc_failsafe,
  input wire logic alloc_release,
  input wire logic alloc_done,
  input wire logic alloc_ok,
  input wire logic [13:0] alloc_blocks,
  input wire logic [7:0] file_count,
  // Flash pins
  input wire logic flash_cs_n,
  input wire logic flash_sclk
);
  // Decoded request conditions
  wire take = cmd_valid && cmd_ready;
  wire bad = cmd_op == 3'h6 && (cmd_len == 16'h0000 || cmd_len > 16'h00ff);
  wire fits = alloc_size <= 25'h100_0000;
  wire [25:0] up = {1'b0, alloc_size} + 26'h000_0fff;
  wire [13:0] need = (alloc_size == 25'h000_0000) ? 14'h0001 : up[25:12];
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_bad_len: assert property (take && bad |=> cmd_done && cmd_error && flash_cs_n)
    else $error("bad program length not refused");
  a_error_done: assert property (cmd_error |-> cmd_done && cmd_ready)
    else $error("error without done");
  a_frame_open: assert property (take && !bad |-> ##[1:3] !flash_cs_n)
    else $error("no frame after command");
  a_no_early: assert property (take && !bad |=> !cmd_done [*8])
    else $error("command ended too soon");
  a_sclk_idle: assert property (flash_cs_n |-> !flash_sclk)
    else $error("link clock outside frame");
  a_huge_file: assert property (alloc_valid && !fits |=> alloc_done && !alloc_ok)
    else $error("oversized file accepted");
  a_full_table: assert property (alloc_valid && file_count == 8'h80 |=> !alloc_ok)
    else $error("file beyond table accepted");
  a_count_step: assert property (alloc_valid && fits && !alloc_release &&
    file_count < 8'h80 |=> alloc_ok && file_count == $past(file_count) + 8'h01)
    else $error("file count not stepped");
  a_plain_blocks: assert property (alloc_valid && fits && !alloc_failsafe
    |=> alloc_blocks == $past(need))
    else $error("block count wrong");
  a_safe_blocks: assert property (alloc_valid && fits && alloc_failsafe
    |=> alloc_blocks == ($past(need) << 1))
    else $error("fail-safe block count wrong");
endmodule // flash_seq_sva
bind boot_store_flash_sequencer flash_seq_sva chk (
  .core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd_op(cmd_op), .cmd_len(cmd_len), .cmd_done(cmd_done), .cmd_error(cmd_error),
  .alloc_valid(alloc_valid), .alloc_size(alloc_size), .alloc_failsafe(alloc_failsafe),
  .alloc_release(alloc_release), .alloc_done(alloc_done), .alloc_ok(alloc_ok),
  .alloc_blocks(alloc_blocks), .file_count(file_count), .flash_cs_n(flash_cs_n),
  .flash_sclk(flash_sclk)
);
`default_nettype wire

// [prog_data_fifo.v]
`timescale 1ns/1ps
`default_nettype none

module prog_data_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire core_clk,
  input wire rst_n,
  // Fill side
  input wire in_valid,
  output reg in_ready,
  input wire [WIDTH-1:0] in_data,
  // Drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  localparam [AW:0] FULL_COUNT = DEPTH;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  reg [AW:0] next_count;
  wire push;
  wire pop;

  // Handshakes
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];

  // Occupancy after this cycle
  always @* begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // Pointers, count and registered ready
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      count <= next_count;
      in_ready <= (next_count != FULL_COUNT);
    end
  end

  // Storage, no reset needed
  always @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule // prog_data_fifo

`default_nettype wire

// [serial_flash_defines.vh]
`ifndef SERIAL_FLASH_DEFINES_VH
`define SERIAL_FLASH_DEFINES_VH

// Flash opcodes
`define OPC_READ_ID 8'h9f
`define OPC_READ_STATUS 8'h05
`define OPC_WRITE_ENABLE 8'h06
`define OPC_CHIP_ERASE 8'hc7
`define OPC_READ_DATA 8'h03
`define OPC_PAGE_PROGRAM 8'h02
`define OPC_SECTOR_ERASE 8'h20
`define OPC_READ_PARAMS 8'h5a

// Command port codes
`define CMD_READ_ID 3'h0
`define CMD_READ_STATUS 3'h1
`define CMD_WRITE_ENABLE 3'h2
`define CMD_CHIP_ERASE 3'h3
`define CMD_SECTOR_ERASE 3'h4
`define CMD_READ_DATA 3'h5
`define CMD_PAGE_PROGRAM 3'h6
`define CMD_READ_PARAMS 3'h7

// Response lengths
`define ID_BYTES 16'h0003
`define STATUS_BYTES 16'h0001

// Status fields
`define STATUS_BUSY_BIT 0
`define STATUS_WEL_BIT 1

// Page program length limit
`define PROG_MAX_BYTES 16'h00ff

// File-system layout
`define FS_BASE_ADDR 24'h00_0000
`define SECTOR_MASK 24'hff_f000
`define BLOCK_SHIFT 12
`define MAX_FILES 8'h80
`define MAX_FILE_SIZE 25'h100_0000
`define FAILSAFE_MIN_BLOCKS 14'h0002

// Timing
`define CLK_PERIOD_NS 25
`define LINK_PERIOD_NS 200
`define LINK_HALF_CYC ((`LINK_PERIOD_NS / 2) / `CLK_PERIOD_NS)
`define CS_GAP_NS 100
`define CS_GAP_CYC ((`CS_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "serial_flash_defines.vh"
module tb_top;
  // Design inputs
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  logic [2:0] cmd_op = 3'h0;
  logic [23:0] cmd_addr = 24'h00_0000;
  logic [15:0] cmd_len = 16'h0000;
  logic wr_valid = 1'b0;
  logic [7:0] wr_data = 8'h00;
  logic alloc_valid = 1'b0;
  logic [24:0] alloc_size = 25'h000_0000;
  logic alloc_failsafe = 1'b0;
  logic alloc_release = 1'b0;
  // Design outputs
  wire cmd_ready, cmd_done, cmd_error, wr_ready, rd_valid, alloc_done, alloc_ok;
  wire flash_cs_n, flash_sclk, flash_mosi, flash_miso;
  wire [7:0] rd_data, status_byte, file_count;
  wire [13:0] alloc_blocks;
  // Bench state
  int error_cnt = 0;
  int compares = 0;
  int exp_cnt = 0;
  int p0, f0;
  logic err;
  logic [23:0] a;
  logic [15:0] lf = 16'h17be;
  logic [7:0] rq[$];
  logic [7:0] pd[$];
  always #12.5 core_clk = ~core_clk;
  boot_store_flash_sequencer uut (
    .core_clk(core_clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_done(cmd_done),
    .cmd_error(cmd_error), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_data(wr_data),
    .rd_valid(rd_valid), .rd_data(rd_data), .status_byte(status_byte),
    .alloc_valid(alloc_valid), .alloc_size(alloc_size), .alloc_failsafe(alloc_failsafe),
    .alloc_release(alloc_release), .alloc_done(alloc_done), .alloc_ok(alloc_ok),
    .alloc_blocks(alloc_blocks), .file_count(file_count), .flash_cs_n(flash_cs_n),
    .flash_sclk(flash_sclk), .flash_mosi(flash_mosi), .flash_miso(flash_miso)
  );
  flash_model model (.cs_n(flash_cs_n), .sclk(flash_sclk), .mosi(flash_mosi), .miso(flash_miso));
  // Collect received bytes
  always @(posedge core_clk) if (rd_valid === 1'b1) rq.push_back(rd_data);
  // Pseudo-random step and expected values
  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [7:0] pat(input logic [23:0] b, input int i, input logic [7:0] s);
    return (b[7:0] + i[7:0]) ^ s;
  endfunction
  function automatic logic [13:0] blocks(input logic [24:0] s, input logic fs);
    logic [13:0] b;
    b = (s == 0) ? 14'h0001 : 14'(({1'b0, s} + 26'h000_0fff) >> 12);
    return fs ? (b << 1) : b;
  endfunction
  task automatic report_and_stop;
    if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  // Issue one command and wait for its done pulse
  task automatic run_cmd(input logic [2:0] op, input logic [23:0] ad, input logic [15:0] n);
    int k;
    rq.delete();
    p0 = model.polls;
    f0 = model.frames;
    cmd_op = op;
    cmd_addr = ad;
    cmd_len = n;
    cmd_valid = 1'b1;
    check(cmd_ready === 1'b1, "not ready");
    @(negedge core_clk);
    cmd_valid = 1'b0;
    for (k = 0; k < 40000 && cmd_done !== 1'b1; k++) @(negedge core_clk);
    if (k == 40000) begin
      check(1'b0, "command hang");
      report_and_stop();
    end
    err = cmd_error;
  endtask
  // Offer one program byte until taken
  task automatic push(input logic [7:0] d);
    int j;
    wr_data = d;
    wr_valid = 1'b1;
    for (j = 0; j < 40000 && wr_ready !== 1'b1; j++) @(negedge core_clk);
    if (j == 40000) begin
      check(1'b0, "fifo hang");
      report_and_stop();
    end
    pd.push_back(d);
    @(negedge core_clk);
  endtask
  // One allocation request or release
  task automatic alloc(input logic [24:0] s, input logic fs, input logic v, input logic rel);
    logic ok;
    ok = s <= 25'h100_0000 && exp_cnt < 128;
    alloc_size = s;
    alloc_failsafe = fs;
    alloc_valid = v;
    alloc_release = rel;
    @(negedge core_clk);
    alloc_valid = 1'b0;
    alloc_release = 1'b0;
    if (v) begin
      check(alloc_done === 1'b1 && alloc_ok === ok, "alloc verdict");
      if (ok) check(alloc_blocks === blocks(s, fs), "alloc blocks");
      if (ok && !rel) exp_cnt++;
    end else if (rel && exp_cnt > 0) exp_cnt--;
    check(file_count === 8'(exp_cnt), "file count");
  endtask
  // Main sequence
  initial begin
    repeat (6) @(negedge core_clk);
    rst_n = 1'b1;
    check(cmd_ready === 1'b1 && flash_cs_n === 1'b1, "reset state");
    @(negedge core_clk);
    run_cmd(`CMD_READ_ID, 24'h00_0000, 16'h0000);
    check(rq.size() == 3 && {rq[0], rq[1], rq[2]} === model.ID_CODE, "id");
    run_cmd(`CMD_WRITE_ENABLE, 24'h00_0000, 16'h0000);
    check(model.polls - p0 == 2 && status_byte[1] === 1'b1, "wel poll");
    run_cmd(`CMD_READ_STATUS, 24'h00_0000, 16'h0000);
    check(rq.size() == 1 && rq[0] === 8'h02, "status");
    run_cmd(`CMD_CHIP_ERASE, 24'h00_0000, 16'h0000);
    check(model.polls - p0 == 3 && model.frames - f0 == 4, "erase");
    check(status_byte[0] === 1'b0, "busy left");
    lf = nxt(lf);
    run_cmd(`CMD_SECTOR_ERASE, {lf, 8'h5d}, 16'h0000);
    check(model.last_addr === {lf[15:4], 12'h000} && model.polls - p0 == 3, "sector");
    for (int r = 0; r < 4; r++) begin
      lf = nxt(lf);
      a = (r == 0) ? 24'h00_0000 : {lf, lf[7:0]};
      run_cmd(`CMD_READ_DATA, a, {13'h0000, lf[2:0]});
      check(rq.size() == lf[2:0] && model.last_addr === a, "read count");
      foreach (rq[i]) check(rq[i] === pat(a, i, 8'ha5), "read data");
    end
    run_cmd(`CMD_READ_PARAMS, 24'h00_0010, 16'h0003);
    check(rq.size() == 3 && rq[2] === pat(24'h00_0010, 2, 8'h3c), "table");
    run_cmd(`CMD_PAGE_PROGRAM, 24'h00_1000, 16'h0000);
    check(err === 1'b1 && model.frames == f0, "len zero");
    run_cmd(`CMD_PAGE_PROGRAM, 24'h00_1000, 16'h0100);
    check(err === 1'b1 && model.frames == f0, "len over");
    for (int i = 0; i < 8; i++) begin
      lf = nxt(lf);
      push(lf[7:0]);
    end
    wr_valid = 1'b0;
    @(negedge core_clk);
    check(wr_ready === 1'b0, "fifo not full");
    fork
      run_cmd(`CMD_PAGE_PROGRAM, 24'h00_2a00, 16'h00ff);
      begin
        for (int i = 8; i < 255; i++) begin
          lf = nxt(lf);
          push(lf[7:0]);
        end
        wr_valid = 1'b0;
      end
    join
    check(err === 1'b0 && model.last_addr === 24'h00_2a00, "program");
    check(model.prog.size() == 255, "program count");
    foreach (pd[i]) check(model.prog[i] === pd[i], "program data");
    alloc(25'h100_0000, 1'b0, 1'b1, 1'b0);
    alloc(25'h100_0001, 1'b1, 1'b1, 1'b0);
    alloc(25'h000_0000, 1'b1, 1'b1, 1'b1);
    for (int i = 0; i < 20; i++) begin
      lf = nxt(lf);
      alloc({lf[8:0], lf}, lf[3], 1'b1, 1'b0);
    end
    for (int i = 0; i < 130 && exp_cnt < 128; i++) alloc(25'h000_1001, 1'b0, 1'b1, 1'b0);
    alloc(25'h000_0001, 1'b0, 1'b1, 1'b0);
    alloc(25'h000_0000, 1'b0, 1'b0, 1'b1);
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
